// ==== src/rms_pkg.sv ====
// Shared constants, carrier types and helpers of the relay matrix sequencer.
// Assumes one 125 MHz clock and a 32-bit Avalon-MM slave with byte addresses.
package rms_pkg;

  // Register byte offsets
  localparam logic [3:0] RMS_COL_OFS  = 4'h0;  // Coil column latch
  localparam logic [3:0] RMS_ROW_OFS  = 4'h4;  // Coil row latch
  localparam logic [3:0] RMS_STAT_OFS = 4'h8;  // Status
  localparam logic [3:0] RMS_MS_OFS   = 4'hC;  // Milliseconds since last latch write

  // Reset values: every drive released
  localparam logic [7:0] RMS_COL_RST = 8'hFF;
  localparam logic [7:0] RMS_ROW_RST = 8'hE0;

  // Row latch field positions
  localparam int RMS_ROW_UNI_EN = 7;  // Unidir drive enable, low = on
  localparam int RMS_ROW_BI_A   = 6;  // Bidir enable a, low = on
  localparam int RMS_ROW_BI_B   = 5;  // Bidir enable b, low = on
  localparam int RMS_ROW_DIR_W  = 5;  // Bidir direction bits [4:0], 1 = pull up

  // Column lines that are pull-ups; the rest are pull-downs
  localparam logic [7:0] RMS_COL_PULLUP_MASK = 8'h55;

  // Status field positions
  localparam int RMS_ST_TRAP      = 0;  // Overload level now
  localparam int RMS_ST_SEEN      = 1;  // Overload edge seen, write 1 to clear
  localparam int RMS_ST_INHIBIT   = 2;  // Inhibit jumper fitted
  localparam int RMS_ST_IDLE      = 3;  // Both latches at idle
  localparam int RMS_ST_ROWIN_LSB = 8;  // Bidir line readback [12:8]

  // Timing
  localparam int RMS_CLK_PERIOD_NS = 8;
  localparam int RMS_MS_TIME_NS    = 1000000;
  localparam int RMS_MS_CYCLES     = RMS_MS_TIME_NS / RMS_CLK_PERIOD_NS;
  localparam int RMS_PRE_W         = 17;

  // Avalon-MM request carrier
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rms_avs_req_t;

  // Relay drive pins, output enables low while driving
  typedef struct packed {
    logic [7:0]               col_drive_out;
    logic [7:0]               col_drive_oe_n;
    logic [RMS_ROW_DIR_W-1:0] bidir_row_drive_out;
    logic [RMS_ROW_DIR_W-1:0] bidir_row_drive_oe_n;
  } rms_drive_t;

  // Core state
  typedef struct packed {
    logic [7:0]           col;
    logic [7:0]           row;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 trap;
    logic                 seen;
    logic [RMS_PRE_W-1:0] pre;
    logic [15:0]          ms;
  } rms_core_t;

  // True when no more than one column output is low
  function automatic logic rms_col_legal(input logic [7:0] col);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      if (!col[i]) n++;
    end
    return n <= 1;
  endfunction : rms_col_legal

endpackage : rms_pkg

// ==== src/rms_drive_stage.sv ====
// Registered relay drive stage: turns latch contents into pin drives.
// Assumes latch inputs come from flip-flops in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module rms_drive_stage (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        coil_column_latch,
  input  wire logic [7:0]        coil_row_latch,
  input  wire logic              relay_inhibit_jumper,
  output var rms_pkg::rms_drive_t relay_drive
);
  import rms_pkg::*;

  rms_drive_t q;       // Registered pins
  rms_drive_t d;       // Next pins
  logic       uni_en;  // Column drives allowed
  logic       bi_en;   // Row drives allowed

  // Drive decode; the jumper overrides any latch content
  always_comb begin
    d      = '0;
    uni_en = !coil_row_latch[RMS_ROW_UNI_EN] && !relay_inhibit_jumper
             && rms_col_legal(coil_column_latch);
    bi_en  = !coil_row_latch[RMS_ROW_BI_A] && !coil_row_latch[RMS_ROW_BI_B]
             && !relay_inhibit_jumper;
    for (int i = 0; i < 8; i++) begin
      // Pull-ups only source, pull-downs only sink
      d.col_drive_oe_n[i] = !(uni_en && !coil_column_latch[i]);
      d.col_drive_out[i]  = RMS_COL_PULLUP_MASK[i] && !d.col_drive_oe_n[i];
    end
    // Bidir lines source or sink by direction bit
    d.bidir_row_drive_out  = coil_row_latch[RMS_ROW_DIR_W-1:0];
    d.bidir_row_drive_oe_n = {RMS_ROW_DIR_W{!bi_en}};
  end

  // Reset leaves every line released
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{col_drive_out: 8'h00, col_drive_oe_n: 8'hFF,
             bidir_row_drive_out: 5'h00, bidir_row_drive_oe_n: 5'h1F};
    end else begin
      q <= d;
    end
  end

  assign relay_drive = q;

  a_inhibit_all_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    relay_inhibit_jumper |=> (&relay_drive.col_drive_oe_n)
                             && (&relay_drive.bidir_row_drive_oe_n))
    else $error("drive active while inhibit fitted");

  a_pull_direction: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((~relay_drive.col_drive_oe_n) & (relay_drive.col_drive_out ^ RMS_COL_PULLUP_MASK))
      == 8'h00)
    else $error("column line driven against its direction");

  a_single_column: assert property (@(posedge ref_clk) disable iff (!rstn)
    rms_col_legal(relay_drive.col_drive_oe_n))
    else $error("more than one column line driven");

  a_row_follows_dir: assert property (@(posedge ref_clk) disable iff (!rstn)
    !relay_inhibit_jumper && !coil_row_latch[RMS_ROW_BI_A] && !coil_row_latch[RMS_ROW_BI_B]
    |=> relay_drive.bidir_row_drive_oe_n == 5'h00
        && relay_drive.bidir_row_drive_out == $past(coil_row_latch[4:0]))
    else $error("bidir lines not driven per direction bits");

endmodule : rms_drive_stage
`default_nettype wire

// ==== src/rms_relay_seq.sv ====
// Relay matrix pulse sequencer: coil latches, overload trap and bus slave.
// Assumes an Avalon-MM master holding each request until waitrequest is low,
// and comparator inputs already synchronous to ref_clk.
//
// Contract
// - Idle: column latch ones, row enables high.
// - Unidir lines one way, bidir lines both ways.
// - Inhibit jumper disables all drives regardless.
// - Any comparator low raises overload trap.
// - Trap is non-maskable, taken on rising edge.
//
// Register map, byte offsets, writes use the low byte
//   0x0  coil_column_latch, a low bit selects a line
//   0x4  coil_row_latch: b7 unidir enable, b6/b5 bidir enables,
//        b4:0 bidir directions, 1 = pull up
//   0x8  status: b0 overload level, b1 overload edge seen,
//        b2 inhibit fitted, b3 both latches idle, b12:8 bidir readback
//   0xC  milliseconds since last latch write, saturating
//
// Bus timing
//   Cycle 0: request seen, waitrequest high, read data captured
//   Cycle 1: waitrequest low, a write lands at the closing edge
//   Pins follow a latch write one edge later
//   Each access costs two cycles; no bursts
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module rms_relay_seq #(
  parameter int unsigned MS_CYCLES = rms_pkg::RMS_MS_CYCLES  // Cycles per millisecond tick
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // Avalon-MM slave
  input  wire rms_pkg::rms_avs_req_t avs_req,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // Board straps and sense lines
  input  wire logic                  relay_inhibit_jumper,
  input  wire logic [3:0]            overload_cmp_n,
  input  wire logic [4:0]            bidir_row_drive_in,
  // Relay drives and trap
  output var rms_pkg::rms_drive_t    relay_drive,
  output logic                       overload_trap
);
  import rms_pkg::*;

  rms_core_t   q;          // Registered state
  rms_core_t   d;          // Next state
  logic        req_act;    // A bus request is present
  logic        wr_take;    // Write takes effect this edge
  logic        latch_wr;   // Either coil latch written
  logic        tick;       // One-millisecond enable
  logic        idle;       // Both latches released
  logic [31:0] status;     // Status word
  logic [31:0] rd_mux;     // Read data for the current address

  // Idle means column all ones and every row enable high
  assign idle = (q.col == RMS_COL_RST)
                && q.row[RMS_ROW_UNI_EN] && q.row[RMS_ROW_BI_A]
                && q.row[RMS_ROW_BI_B];

  // Status word assembly
  always_comb begin
    status = 32'h0000_0000;
    status[RMS_ST_TRAP]    = q.trap;
    status[RMS_ST_SEEN]    = q.seen;
    status[RMS_ST_INHIBIT] = relay_inhibit_jumper;
    status[RMS_ST_IDLE]    = idle;
    status[RMS_ST_ROWIN_LSB +: RMS_ROW_DIR_W] = bidir_row_drive_in;
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    case (avs_req.address)
      RMS_COL_OFS:  rd_mux = {24'h00_0000, q.col};
      RMS_ROW_OFS:  rd_mux = {24'h00_0000, q.row};
      RMS_STAT_OFS: rd_mux = status;
      RMS_MS_OFS:   rd_mux = {16'h0000, q.ms};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the wait cycle so the answer
  // comes from a flip-flop; the cost is the fixed wait state
  // Bus handshake: one wait cycle, then the answer
  assign req_act  = avs_req.read || avs_req.write;
  assign wr_take  = avs_req.write && q.ack && avs_req.byteenable[0];
  assign latch_wr = wr_take
                    && (avs_req.address == RMS_COL_OFS || avs_req.address == RMS_ROW_OFS);

  // Only a ruler for software; it never ends a pulse on its own
  // Millisecond prescaler wraps once per period
  assign tick = (q.pre == RMS_PRE_W'(MS_CYCLES - 1));

  // Next-state logic
  always_comb begin
    d = q;

    // Acknowledge on the second cycle of each request
    d.ack = req_act && !q.ack;
    if (req_act && !q.ack) begin
      d.rdata = rd_mux;
    end

    // Latch writes; software keeps the sequence order itself
    // No order is enforced here; the drive stage alone guards the pins
    if (wr_take) begin
      case (avs_req.address)
        RMS_COL_OFS: begin
          d.col = avs_req.writedata[7:0];
        end
        RMS_ROW_OFS: begin
          d.row = avs_req.writedata[7:0];
        end
        RMS_STAT_OFS: begin
          // Write one clears the overload flag
          if (avs_req.writedata[RMS_ST_SEEN]) begin
            d.seen = 1'b0;
          end
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end

    // Elapsed time lets software pace hold and decay waits
    if (latch_wr) begin
      d.pre = '0;
      d.ms  = 16'h0000;
    end else if (tick) begin
      d.pre = '0;
      if (q.ms != 16'hFFFF) begin
        d.ms = q.ms + 16'h0001;  // Saturates rather than wrapping
      end
    end else begin
      d.pre = q.pre + RMS_PRE_W'(1);
    end

    // Inputs are taken as synchronous; hysteresis is analog, not here
    // Wire-OR of low comparators, inverted into the trap
    d.trap = !(&overload_cmp_n);
    // Rising edge sets the flag; a set beats a clear in the same cycle
    if (d.trap && !q.trap) begin
      d.seen = 1'b1;
    end
  end

  // State register; reset releases every relay drive
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{col: RMS_COL_RST, row: RMS_ROW_RST, ack: 1'b0, rdata: 32'h0000_0000,
             trap: 1'b0, seen: 1'b0, pre: '0, ms: 16'h0000};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign avs_waitrequest = req_act && !q.ack;
  assign avs_readdata    = q.rdata;
  assign overload_trap   = q.trap;  // no mask in the path

  // Pin drive stage, gated by the inhibit jumper
  rms_drive_stage u_drive (
    .ref_clk              (ref_clk),
    .rstn                 (rstn),
    .coil_column_latch    (q.col),
    .coil_row_latch       (q.row),
    .relay_inhibit_jumper (relay_inhibit_jumper),
    .relay_drive          (relay_drive)
  );

  // Checks

  // Reset leaves both latches idle
  a_reset_idle: assert property (@(posedge ref_clk)
    $rose(rstn) |-> idle)
    else $error("latches not idle after reset");

  // Idle latches keep every line released
  a_idle_no_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
    idle ##1 idle |-> (&relay_drive.col_drive_oe_n) && (&relay_drive.bidir_row_drive_oe_n))
    else $error("drive active while latches idle");

  // Trap follows any low comparator one cycle later
  a_trap_rises: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(&overload_cmp_n) |=> overload_trap)
    else $error("overload did not raise trap");

  // Trap drops once every comparator is high
  a_trap_falls: assert property (@(posedge ref_clk) disable iff (!rstn)
    (&overload_cmp_n) |=> !overload_trap)
    else $error("trap high without overload");

  // Trap rise is recorded in the status flag
  a_trap_edge_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(overload_trap) |-> status[RMS_ST_SEEN])
    else $error("trap edge not recorded");

  // Flag stands until software writes
  a_flag_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    status[RMS_ST_SEEN] && !wr_take |=> status[RMS_ST_SEEN])
    else $error("overload flag lost without a clear");

  // Exactly one wait state per access
  a_wait_one: assert property (@(posedge ref_clk) disable iff (!rstn)
    req_act && !q.ack ##1 req_act |-> !avs_waitrequest)
    else $error("answer not given on second cycle");

  // Column latch takes the written byte
  a_col_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_take && avs_req.address == RMS_COL_OFS |=> q.col == $past(avs_req.writedata[7:0]))
    else $error("column latch write lost");

  // All-ones column write frees the column lines
  a_col_release: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_take && avs_req.address == RMS_COL_OFS && avs_req.writedata[7:0] == 8'hFF
    |=> ##1 (&relay_drive.col_drive_oe_n))
    else $error("column drives still on after release");

  // Bidir enable a high frees the bidir lines
  a_row_release: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_take && avs_req.address == RMS_ROW_OFS && avs_req.writedata[RMS_ROW_BI_A]
    |=> ##1 (&relay_drive.bidir_row_drive_oe_n))
    else $error("bidir drives still on after release");

  // Any latch write restarts the elapsed timer
  a_ms_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
    latch_wr |=> q.ms == 16'h0000 && q.pre == '0)
    else $error("elapsed timer not restarted");

  // Writes never land in the wait cycle
  a_no_early_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.write && !q.ack |=> $stable(q.col) && $stable(q.row))
    else $error("latch changed before the answer");

  // A write with the low lane masked is acknowledged and dropped
  a_masked_lane: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.write && !avs_req.byteenable[0] |=> $stable(q.col) && $stable(q.row))
    else $error("masked write changed a latch");

  // Row latch takes the written byte
  a_row_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_take && avs_req.address == RMS_ROW_OFS |=> q.row == $past(avs_req.writedata[7:0]))
    else $error("row latch write lost");

  // Read data stands between answers
  a_rdata_stands: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(req_act && !q.ack) |=> $stable(avs_readdata))
    else $error("read data changed without a request");

  // Column read returns the latch
  a_col_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.read && !q.ack && avs_req.address == RMS_COL_OFS
    |=> avs_readdata == {24'h00_0000, $past(q.col)})
    else $error("column read data wrong");

  // Row read returns the latch
  a_row_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.read && !q.ack && avs_req.address == RMS_ROW_OFS
    |=> avs_readdata == {24'h00_0000, $past(q.row)})
    else $error("row read data wrong");

  // Status read carries the bidir line levels
  a_line_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.read && !q.ack && avs_req.address == RMS_STAT_OFS
    |=> avs_readdata[RMS_ST_ROWIN_LSB +: RMS_ROW_DIR_W] == $past(bidir_row_drive_in))
    else $error("bidir readback wrong");

  // Elapsed time read returns the counter
  a_ms_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.read && !q.ack && avs_req.address == RMS_MS_OFS
    |=> avs_readdata == {16'h0000, $past(q.ms)})
    else $error("elapsed time read data wrong");

  // Unaligned offsets read zero
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    avs_req.read && !q.ack && avs_req.address[1:0] != 2'b00
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Clear works when no new edge arrives
  a_seen_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_take && avs_req.address == RMS_STAT_OFS && avs_req.writedata[RMS_ST_SEEN]
    && (q.trap || (&overload_cmp_n)) |=> !status[RMS_ST_SEEN])
    else $error("overload flag not cleared");

  // A new overload edge always sets the flag, even against a clear
  a_seen_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
    !q.trap && !(&overload_cmp_n) |=> status[RMS_ST_SEEN])
    else $error("overload edge lost");

  // Elapsed count steps once per tick
  a_ms_counts: assert property (@(posedge ref_clk) disable iff (!rstn)
    !latch_wr && tick && q.ms != 16'hFFFF |=> q.ms == $past(q.ms) + 16'h0001)
    else $error("elapsed count did not step");

  // Elapsed count stands between ticks
  a_ms_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    !latch_wr && !tick |=> $stable(q.ms))
    else $error("elapsed count moved between ticks");

  // Prescaler stays inside one period
  a_pre_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
    q.pre <= RMS_PRE_W'(MS_CYCLES - 1))
    else $error("prescaler past its period");

endmodule : rms_relay_seq
`default_nettype wire

// ==== dv/rms_coil_model.sv ====
// Far-side model: bidir line readback and the four overload comparators.
// Assumes the sequencer drive struct and a trip command from the bench.
`timescale 1ns/100ps
`default_nettype none
module rms_coil_model (
  input  wire logic                ref_clk,
  input  wire rms_pkg::rms_drive_t relay_drive,
  input  wire logic [3:0]          trip,
  output logic [3:0]               overload_cmp_n,
  output logic [4:0]               bidir_row_drive_in
);
  import rms_pkg::*;
  logic [4:0] last_q;  // Inverse of the level last seen on each bidir line
  initial last_q = 5'h00;
  // Tripped channel pulls its comparator low
  assign overload_cmp_n = ~trip;
  // Released line floats: show a level that flips every cycle
  always @(posedge ref_clk) begin
    last_q <= ~bidir_row_drive_in;
  end
  // Driven line reads back either polarity
  assign bidir_row_drive_in = (relay_drive.bidir_row_drive_out & ~relay_drive.bidir_row_drive_oe_n)
                            | (last_q & relay_drive.bidir_row_drive_oe_n);
endmodule : rms_coil_model
`default_nettype wire

// ==== dv/rms_relay_seq_tb_top.sv ====
// Bench for the relay sequencer: bus tasks, scenario tasks, verdict.
// Assumes one 125 MHz clock and the coil model on the far side.
`timescale 1ns/100ps
`default_nettype none
module rms_relay_seq_tb_top;
  import rms_pkg::*;
  localparam int MS = 10;  // Short millisecond tick for simulation
  logic         ref_clk, rstn, jumper;
  rms_avs_req_t req;
  logic [31:0]  rdata, q;
  logic         wait_r, trap_o;
  logic [3:0]   cmp_n, trip;
  logic [4:0]   bin;
  rms_drive_t   drv;
  int           miscompares, check_count, cycles;
  // Clock and time-zero inputs
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  rms_relay_seq #(.MS_CYCLES(MS)) uut (.ref_clk(ref_clk), .rstn(rstn), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wait_r), .relay_inhibit_jumper(jumper),
    .overload_cmp_n(cmp_n), .bidir_row_drive_in(bin), .relay_drive(drv), .overload_trap(trap_o));
  rms_coil_model far (.ref_clk(ref_clk), .relay_drive(drv), .trip(trip),
    .overload_cmp_n(cmp_n), .bidir_row_drive_in(bin));
  // Verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Hang guard, well above the whole run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // Register or bit result
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // Full drive struct result
  task cmp_drv(input rms_drive_t got, input rms_drive_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_drv
  // One Avalon cycle; an edge passes first so no strobe is set twice in a step
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
    // Waitrequest and read data are taken at the rising edge itself
    @(posedge ref_clk);
    while (wait_r !== 1'b0) @(posedge ref_clk);
    q = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d}, 4'hF);
  endtask : wr
  task rd(input logic [3:0] a);
    bus(1'b0, a, 32'h00000000, 4'hF);
  endtask : rd
  // Let the registered drive stage catch up
  task settle;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  // Reset state of latches, status and pins
  task t_reset;
    rd(RMS_COL_OFS);  cmp(q, 32'h000000FF);
    rd(RMS_ROW_OFS);  cmp(q, 32'h000000E0);
    rd(RMS_STAT_OFS); cmp(q & 32'hF, 32'h8);
    cmp_drv(drv, {8'h00, 8'hFF, 5'h00, 5'h1F});
  endtask : t_reset
  // Full insert sequence, pull-down on column line 1
  task t_pulse;
    wr(RMS_COL_OFS, 8'hFD);
    wr(RMS_ROW_OFS, 8'h70);
    settle; cmp_drv(drv, {8'h00, 8'hFD, 5'h10, 5'h1F});
    wr(RMS_ROW_OFS, 8'h10);
    settle; cmp_drv(drv, {8'h00, 8'hFD, 5'h10, 5'h00});
    rd(RMS_STAT_OFS); cmp(q, 32'h00001000);
    repeat (15 * MS) @(posedge ref_clk);
    rd(RMS_MS_OFS); cmp({31'h0, q >= 15 && q <= 16}, 32'h1);
    wr(RMS_COL_OFS, 8'hFF);
    settle; cmp_drv(drv, {8'h00, 8'hFF, 5'h10, 5'h00});
    repeat (5 * MS) @(posedge ref_clk);
    wr(RMS_ROW_OFS, 8'hF0);
    settle; cmp_drv(drv, {8'h00, 8'hFF, 5'h10, 5'h1F});
    rd(RMS_STAT_OFS); cmp(q & 32'hF, 32'h8);
  endtask : t_pulse
  // Pull-up line, then jumper, then two columns low
  task t_inhibit;
    wr(RMS_COL_OFS, 8'hFE);
    wr(RMS_ROW_OFS, 8'h70);
    settle; cmp_drv(drv, {8'h01, 8'hFE, 5'h10, 5'h1F});
    @(posedge ref_clk); jumper <= 1'b1;
    settle; cmp({19'h0, drv.col_drive_oe_n, drv.bidir_row_drive_oe_n}, 32'h1FFF);
    rd(RMS_STAT_OFS); cmp(q & 32'hF, 32'h4);
    @(posedge ref_clk); jumper <= 1'b0;
    wr(RMS_COL_OFS, 8'hFC);
    settle; cmp({24'h0, drv.col_drive_oe_n}, 32'hFF);
    wr(RMS_COL_OFS, 8'hFF);
    wr(RMS_ROW_OFS, 8'hF0);
  endtask : t_inhibit
  // Each comparator in turn raises the trap; seen flag clears by write-one
  task t_trap;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk); trip <= 4'h1 << i;
      settle; cmp({31'h0, trap_o}, 32'h1);
      rd(RMS_STAT_OFS); cmp(q & 32'h3, 32'h3);
      @(posedge ref_clk); trip <= 4'h0;
      settle; cmp({31'h0, trap_o}, 32'h0);
      rd(RMS_STAT_OFS); cmp(q & 32'h3, 32'h2);
      wr(RMS_STAT_OFS, 8'h02);
      rd(RMS_STAT_OFS); cmp(q & 32'h3, 32'h0);
      // Clear while still overloaded: the trip edge sets the flag, the write clears it, no later edge
      @(posedge ref_clk); trip <= 4'h1 << i;
      wr(RMS_STAT_OFS, 8'h02);
      rd(RMS_STAT_OFS); cmp(q & 32'h3, 32'h1);
      @(posedge ref_clk); trip <= 4'h0;
      wr(RMS_COL_OFS, 8'hFF);
    end
  endtask : t_trap
  // Masked byte lane leaves the column latch alone; unmapped offset reads zero
  task t_refuse;
    bus(1'b1, RMS_COL_OFS, 32'h00000000, 4'h0);
    rd(RMS_COL_OFS); cmp(q, 32'h000000FF);
    wr(4'h2, 8'h00);
    rd(4'h2); cmp(q, 32'h00000000);
  endtask : t_refuse
  // Mid-run reset from a live drive returns latches and pins to idle
  task t_midreset;
    wr(RMS_COL_OFS, 8'hFD);
    wr(RMS_ROW_OFS, 8'h10);
    settle; cmp_drv(drv, {8'h00, 8'hFD, 5'h10, 5'h00});
    @(posedge ref_clk); rstn <= 1'b0;
    @(negedge ref_clk); cmp_drv(drv, {8'h00, 8'hFF, 5'h00, 5'h1F});
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
  endtask : t_midreset
  // Main sequence
  initial begin
    rstn = 1'b0; jumper = 1'b0; trip = 4'h0; req = '0;
    miscompares = 0; check_count = 0; cycles = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_pulse;
    t_inhibit;
    t_trap;
    t_refuse;
    t_midreset;
    finish_test();
  end
endmodule : rms_relay_seq_tb_top
`default_nettype wire
